// ---- logic/io_window_decode.sv ----
// claims a pci io transaction whose address falls in the programmed window
`timescale 1ns/1ps
`include "pci_hdr_cfg.svh"
module io_window_decode
  import pci_hdr_pkg::*;
(
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_b_i,
  input  wire logic                   enhanced_i,
  input  wire logic [`IO_BASE_W-1:0]  base_bits_i,
  input  wire logic                   io_cmd_valid_i,
  input  wire logic [31:0]            io_addr_i,
  output logic                        io_claim_o
);
  logic [`IO_BASE_W-1:0] mask;
  logic                  hit;

  always_comb
  begin
    mask = io_cmp_mask(enhanced_i);
    hit  = ((io_addr_i[`IO_BASE_MSB:`IO_BASE_LSB] ^ base_bits_i) & mask) == '0; // RQ21
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      io_claim_o <= 1'b0;
    else
      io_claim_o <= io_cmd_valid_i && hit; // RQ21
  end
endmodule

// ---- logic/pci_config_header_regs.sv ----
// pci configuration header misc word and io window base word, two access ports
//
// Summary of operation
// RQ1 - misc word: only latency timer bits writable
// RQ2 - misc word resets to zero
// RQ3 - self-test capable flag reads zero
// RQ4 - self-test start flag reads zero
// RQ5 - misc bits 29 and 28 read zero
// RQ6 - self-test completion code reads zero
// RQ7 - multifunction flag reads zero
// RQ8 - header layout type reads type zero
// RQ9 - latency timer bounds master bus tenure
// RQ10 - line size field reads zero
// RQ11 - io base holds compared upper bits
// RQ12 - base variant: bits 30..20 writable
// RQ13 - base variant: bits 19..8 zero
// RQ14 - enhanced variant: bits 31..8 writable
// RQ15 - software assigns 1 MB or 256 B window
// RQ16 - io base word resets to one
// RQ17 - program io base before io transfers
// RQ18 - io base bits 7..2 read zero
// RQ19 - reserved bit 1 reads zero, write zero
// RQ20 - space kind indicator reads one
// RQ21 - claim io only on base match
`timescale 1ns/1ps
`include "pci_hdr_cfg.svh"
module pci_config_header_regs
  import pci_hdr_pkg::*;
(
  input  wire logic          core_clk_i,
  input  wire logic          rst_b_i,
  input  wire logic          soft_rst_i,
  input  wire logic          enhanced_variant_i,
  input  wire cfg_req_t      pci_cfg_req_i,
  output cfg_rsp_t           pci_cfg_rsp_o,
  input  wire cfg_req_t      local_req_i,
  output cfg_rsp_t           local_rsp_o,
  input  wire logic          io_cmd_valid_i,
  input  wire logic [31:0]   io_addr_i,
  output logic               io_claim_o,
  input  wire logic          tenure_start_i,
  input  wire logic          tenure_active_i,
  output logic               tenure_expired_o,
  output logic [`LAT_W-1:0]  master_latency_timer_o,
  output logic               variant_enhanced_o
);

  ////////////////////////////////////////////////////////////////////////////
  // variant strap

  // the strap is caught on the first clock after reset release and then held,
  // so a strap that wobbles later cannot reshape the write masks mid-run
  logic strap_taken_r;
  logic enhanced_r;

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      strap_taken_r <= 1'b0;
    else
      strap_taken_r <= 1'b1;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      enhanced_r <= 1'b0;
    else if (!strap_taken_r)
      enhanced_r <= enhanced_variant_i;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      variant_enhanced_o <= 1'b0;
    else
      variant_enhanced_o <= enhanced_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // storage

  // only the latency byte and io base bits 31..8 are held; everything else is wired at read time
  logic [`LAT_W-1:0]      latency_r;
  logic [`LAT_W-1:0]      latency_nxt;
  logic [`IO_BASE_W-1:0]  io_base_r;
  logic [`IO_BASE_W-1:0]  io_base_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // write path

  logic        pci_wr;
  logic        loc_wr;
  logic [31:0] pci_be_mask;
  logic [31:0] loc_be_mask;
  logic [31:0] misc_word;
  logic [31:0] io_word;
  logic [31:0] misc_after_loc;
  logic [31:0] misc_after_pci;
  logic [31:0] io_after_loc;
  logic [31:0] io_after_pci;
  logic [31:0] misc_wr_mask;
  logic [31:0] io_mask;

  // byte enables widen to bit masks, one lane at a time
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1)
    begin : g_lane
      assign pci_be_mask[lane*8 +: 8] = {8{pci_cfg_req_i.byte_en[lane]}};
      assign loc_be_mask[lane*8 +: 8] = {8{local_req_i.byte_en[lane]}};
    end
  endgenerate

  always_comb
  begin
    pci_wr       = pci_cfg_req_i.valid && pci_cfg_req_i.write;
    loc_wr       = local_req_i.valid && local_req_i.write;
    misc_wr_mask = '0;
    misc_wr_mask[`LAT_MSB:`LAT_LSB] = '1; // RQ1
    io_mask      = io_wr_mask(enhanced_r); // RQ12 RQ14
  end

  // a write lands only on writable bits and enabled byte lanes
  function automatic logic [31:0] merge(input logic [31:0] old_val,
                                        input logic [31:0] new_val,
                                        input logic [31:0] mask);
    merge = (old_val & ~mask) | (new_val & mask);
  endfunction

  // local bus applied first, pci second: on a same-cycle clash the pci
  // configuring master wins the overlapping bits
  always_comb
  begin
    misc_after_loc = misc_word;
    if (loc_wr && local_req_i.index == `IDX_HDR_MISC)
      misc_after_loc = merge(misc_word, local_req_i.wdata, misc_wr_mask & loc_be_mask); // RQ1
    misc_after_pci = misc_after_loc;
    if (pci_wr && pci_cfg_req_i.index == `IDX_HDR_MISC)
      misc_after_pci = merge(misc_after_loc, pci_cfg_req_i.wdata, misc_wr_mask & pci_be_mask); // RQ1
    latency_nxt = misc_after_pci[`LAT_MSB:`LAT_LSB];
  end

  always_comb
  begin
    io_after_loc = io_word;
    if (loc_wr && local_req_i.index == `IDX_IO_BASE)
      io_after_loc = merge(io_word, local_req_i.wdata, io_mask & loc_be_mask); // RQ12 RQ14
    io_after_pci = io_after_loc;
    if (pci_wr && pci_cfg_req_i.index == `IDX_IO_BASE)
      io_after_pci = merge(io_after_loc, pci_cfg_req_i.wdata, io_mask & pci_be_mask); // RQ12 RQ14
    io_base_nxt = io_after_pci[`IO_BASE_MSB:`IO_BASE_LSB];
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      latency_r <= `LAT_RST; // RQ2
    else if (soft_rst_i)
      latency_r <= `LAT_RST; // RQ2
    else
      latency_r <= latency_nxt;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      io_base_r <= `IO_BASE_BITS_RST; // RQ16
    else if (soft_rst_i)
      io_base_r <= `IO_BASE_BITS_RST; // RQ16
    else
      io_base_r <= io_base_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read view

  always_comb
  begin
    misc_word = {`SELFTEST_CAP_VAL,    // RQ3
                 `SELFTEST_START_VAL,  // RQ4
                 `SELFTEST_RSVD_VAL,   // RQ5
                 `SELFTEST_CODE_VAL,   // RQ6
                 `MULTIFUNC_VAL,       // RQ7
                 `LAYOUT_TYPE_VAL,     // RQ8
                 latency_r,
                 `LINE_SIZE_VAL};      // RQ10
  end

  // io base bits outside the variant's writable set read as zero, because the
  // read view ands the register with that same mask
  always_comb
  begin
    io_word = {io_base_r & io_mask[`IO_BASE_MSB:`IO_BASE_LSB], // RQ11 RQ13
               `IO_LOW_ZERO_VAL,   // RQ18
               `IO_RSVD_VAL,       // RQ19
               `IO_SPACE_KIND_VAL}; // RQ20
  end

  // the memory window word is not decoded; like any other unused index it is answered as zero here
  function automatic logic [31:0] read_word(input logic [`IDX_W-1:0] idx,
                                            input logic [31:0] misc,
                                            input logic [31:0] io);
    if (idx == `IDX_HDR_MISC)
      read_word = misc;
    else if (idx == `IDX_IO_BASE)
      read_word = io;
    else
      read_word = '0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pci configuration port answer

  // reads return the view before any same-cycle write takes effect
  // ack and data share one process so the answer struct has a single writer
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pci_cfg_rsp_o.ack   <= 1'b0;
      pci_cfg_rsp_o.rdata <= '0;
    end
    else
    begin
      pci_cfg_rsp_o.ack <= pci_cfg_req_i.valid;
      if (pci_cfg_req_i.valid && !pci_cfg_req_i.write)
        pci_cfg_rsp_o.rdata <= read_word(pci_cfg_req_i.index, misc_word, io_word);
      else
        pci_cfg_rsp_o.rdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // local peripheral bus port answer

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      local_rsp_o.ack   <= 1'b0;
      local_rsp_o.rdata <= '0;
    end
    else
    begin
      local_rsp_o.ack <= local_req_i.valid;
      if (local_req_i.valid && !local_req_i.write)
        local_rsp_o.rdata <= read_word(local_req_i.index, misc_word, io_word);
      else
        local_rsp_o.rdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // latency timer out

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      master_latency_timer_o <= `LAT_RST;
    else
      master_latency_timer_o <= latency_r; // RQ9
  end

  tenure_timer u_tenure_timer (
    .core_clk_i      (core_clk_i),
    .rst_b_i         (rst_b_i),
    .tenure_start_i  (tenure_start_i),
    .tenure_active_i (tenure_active_i),
    .latency_i       (latency_r),
    .expired_o       (tenure_expired_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // io window claim

  // the claim trusts software to program the base first; before that the
  // window sits at zero and decodes the bottom of io space
  io_window_decode u_io_window_decode (
    .core_clk_i     (core_clk_i),
    .rst_b_i        (rst_b_i),
    .enhanced_i     (enhanced_r),
    .base_bits_i    (io_base_r),
    .io_cmd_valid_i (io_cmd_valid_i),
    .io_addr_i      (io_addr_i),
    .io_claim_o     (io_claim_o)
  );

endmodule

// ---- logic/pci_hdr_cfg.svh ----
// constants for the configuration header misc word and io window base word
`ifndef PCI_HDR_CFG_SVH
`define PCI_HDR_CFG_SVH

// register indices (dword number in configuration space)
`define IDX_HDR_MISC        2'h3
`define IDX_IO_BASE         2'h0
`define IDX_MEM0_BASE       2'h1
`define IDX_W               2

// reset values
`define HDR_MISC_RST        32'h0000_0000
`define IO_BASE_RST         32'h0000_0001
`define LAT_RST             8'h00
`define IO_BASE_BITS_RST    24'h00_0000

// header misc word layout
`define LAT_MSB             15
`define LAT_LSB             8
`define LAT_W               8
`define SELFTEST_CAP_VAL    1'b0
`define SELFTEST_START_VAL  1'b0
`define SELFTEST_RSVD_VAL   2'h0
`define SELFTEST_CODE_VAL   4'h0
`define MULTIFUNC_VAL       1'b0
`define LAYOUT_TYPE_VAL     7'h00
`define LINE_SIZE_VAL       8'h00

// io window base word layout
`define IO_BASE_MSB         31
`define IO_BASE_LSB         8
`define IO_BASE_W           24
`define IO_LOW_ZERO_VAL     6'h00
`define IO_RSVD_VAL         1'b0
`define IO_SPACE_KIND_VAL   1'b1
`define IO_WR_MASK_BASE     32'h7ff0_0000
`define IO_WR_MASK_ENH      32'hffff_ff00
`define IO_CMP_MASK_BASE    24'hfff000
`define IO_CMP_MASK_ENH     24'hffffff

// memory window 0 base word layout (behaviour lives elsewhere)
`define MEM0_BASE_MSB       31
`define MEM0_BASE_LSB       20
`define MEM0_PREF_BIT       3
`define MEM0_TYPE_MSB       2
`define MEM0_TYPE_LSB       1
`define MEM0_KIND_BIT       0

`define TIMER_ZERO          8'h00
`define TIMER_ONE           8'h01

`endif

// ---- logic/pci_hdr_pkg.sv ----
// types and shared decode helpers for the configuration header registers
package pci_hdr_pkg;
  `include "pci_hdr_cfg.svh"

  typedef struct packed {
    logic                valid;
    logic                write;
    logic [`IDX_W-1:0]   index;
    logic [3:0]          byte_en;
    logic [31:0]         wdata;
  } cfg_req_t;

  typedef struct packed {
    logic                ack;
    logic [31:0]         rdata;
  } cfg_rsp_t;

  // address bits above the io window that take part in the claim compare
  function automatic logic [`IO_BASE_W-1:0] io_cmp_mask(input logic enhanced);
    io_cmp_mask = enhanced ? `IO_CMP_MASK_ENH : `IO_CMP_MASK_BASE;
  endfunction

  // bits of the io base word that accept a write
  function automatic logic [31:0] io_wr_mask(input logic enhanced);
    io_wr_mask = enhanced ? `IO_WR_MASK_ENH : `IO_WR_MASK_BASE;
  endfunction
endpackage

// ---- logic/tenure_timer.sv ----
// counts down the master latency timer during a bus tenure
`timescale 1ns/1ps
`include "pci_hdr_cfg.svh"
module tenure_timer
  import pci_hdr_pkg::*;
(
  input  wire logic                core_clk_i,
  input  wire logic                rst_b_i,
  input  wire logic                tenure_start_i,
  input  wire logic                tenure_active_i,
  input  wire logic [`LAT_W-1:0]   latency_i,
  output logic                     expired_o
);
  logic [`LAT_W-1:0] count_r;
  logic [`LAT_W-1:0] count_nxt;

  always_comb
  begin
    count_nxt = count_r;
    if (tenure_start_i)
      count_nxt = latency_i; // RQ9
    else if (tenure_active_i && count_r != `TIMER_ZERO)
      count_nxt = count_r - `TIMER_ONE;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      count_r <= `TIMER_ZERO;
    else
      count_r <= count_nxt;
  end

  // a zero timer expires one cycle after the start, like a timer of one, as pci expects
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      expired_o <= 1'b0;
    else
      expired_o <= tenure_active_i && !tenure_start_i && count_nxt == `TIMER_ZERO; // RQ9
  end
endmodule

// ---- testbench/cfg_host.sv ----
// configuring master model: one configuration access at a time
`timescale 1ns/1ps
`include "pci_hdr_cfg.svh"
module cfg_host
  import pci_hdr_pkg::*;
(
  input  wire logic     core_clk_i,
  output cfg_req_t      req_o,
  input  wire cfg_rsp_t rsp_i
);
  initial req_o = '0;

  // idle wdata is inverted so a stale value is never mistaken for live data
  task automatic access(input logic w, input logic [1:0] idx, input logic [3:0] be,
                        input logic [31:0] wd, output logic [31:0] rd, output logic ok);
    @(posedge core_clk_i);
    req_o <= '{valid: 1'b1, write: w, index: idx, byte_en: be, wdata: wd & ~32'h2};
    @(posedge core_clk_i);
    req_o <= '{valid: 1'b0, write: 1'b0, index: ~idx, byte_en: 4'h0, wdata: ~wd};
    @(posedge core_clk_i);
    rd = rsp_i.rdata;
    ok = rsp_i.ack;
  endtask
endmodule

// ---- testbench/pci_hdr_asserts.sv ----
// concurrent checks on the configuration header register ports
`timescale 1ns/1ps
`include "pci_hdr_cfg.svh"
module pci_hdr_asserts
  import pci_hdr_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              soft_rst_i,
  input  wire logic              enhanced_variant_i,
  input  wire cfg_req_t          pci_cfg_req_i,
  input  wire cfg_rsp_t          pci_cfg_rsp_o,
  input  wire cfg_req_t          local_req_i,
  input  wire cfg_rsp_t          local_rsp_o,
  input  wire logic              io_cmd_valid_i,
  input  wire logic [31:0]       io_addr_i,
  input  wire logic              io_claim_o,
  input  wire logic              tenure_start_i,
  input  wire logic              tenure_active_i,
  input  wire logic              tenure_expired_o,
  input  wire logic [`LAT_W-1:0] master_latency_timer_o,
  input  wire logic              variant_enhanced_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  chk_pci_ack_pulse: assert property (pci_cfg_req_i.valid |=> pci_cfg_rsp_o.ack)
    else $error("pci access not acknowledged");
  chk_local_ack_pulse: assert property (local_req_i.valid |=> local_rsp_o.ack)
    else $error("local access not acknowledged");
  chk_misc_fixed_bits: assert property (pci_cfg_req_i.valid && !pci_cfg_req_i.write
    && pci_cfg_req_i.index == `IDX_HDR_MISC |=> pci_cfg_rsp_o.rdata[31:16] == 16'h0000
    && pci_cfg_rsp_o.rdata[7:0] == `LINE_SIZE_VAL) else $error("misc word fixed bits wrong");
  chk_io_fixed_bits: assert property (pci_cfg_req_i.valid && !pci_cfg_req_i.write
    && pci_cfg_req_i.index == `IDX_IO_BASE |=> pci_cfg_rsp_o.rdata[7:0] == 8'h01
    && (variant_enhanced_o || pci_cfg_rsp_o.rdata[31] == 1'b0 && pci_cfg_rsp_o.rdata[19:8] == 12'h000))
    else $error("io base fixed bits wrong");
  chk_latency_write_lands: assert property ((pci_cfg_req_i.valid && pci_cfg_req_i.write
    && pci_cfg_req_i.index == `IDX_HDR_MISC && pci_cfg_req_i.byte_en[1] && !soft_rst_i)
    ##1 !(soft_rst_i || pci_cfg_req_i.valid || local_req_i.valid)
    |=> master_latency_timer_o == $past(pci_cfg_req_i.wdata[15:8], 2)) else $error("latency write lost");
  chk_soft_reset_clears: assert property (soft_rst_i |-> ##2 master_latency_timer_o == `TIMER_ZERO)
    else $error("soft reset left latency set");
  chk_claim_has_cause: assert property (io_claim_o |-> $past(io_cmd_valid_i))
    else $error("io claim without command");
  chk_expire_in_tenure: assert property ($rose(tenure_expired_o) |-> $past(tenure_active_i))
    else $error("timer expired outside tenure");

  cover property (io_claim_o);
  cover property (tenure_expired_o);
  cover property (soft_rst_i ##1 local_rsp_o.ack);
endmodule

bind pci_config_header_regs pci_hdr_asserts i_pci_hdr_asserts (.core_clk_i, .rst_b_i, .soft_rst_i,
  .enhanced_variant_i, .pci_cfg_req_i, .pci_cfg_rsp_o, .local_req_i, .local_rsp_o, .io_cmd_valid_i,
  .io_addr_i, .io_claim_o, .tenure_start_i, .tenure_active_i, .tenure_expired_o, .master_latency_timer_o,
  .variant_enhanced_o);

// ---- testbench/tb_top.sv ----
// self-checking bench for the configuration header registers
`timescale 1ns/1ps
`include "pci_hdr_cfg.svh"
module tb_top;
  import pci_hdr_pkg::*;

  typedef struct packed {
    logic        v;
    logic        lp;
    logic        w;
    logic [1:0]  idx;
    logic [3:0]  be;
    logic [31:0] wd;
    logic [31:0] exp;
  } row_t;

  logic                clk;
  logic                rst_b    = 1'b0;
  logic                soft_rst = 1'b0;
  logic                enh      = 1'b0;
  logic                io_valid = 1'b0;
  logic [31:0]         io_addr  = 32'h0;
  logic                t_start  = 1'b0;
  logic                t_active = 1'b0;
  cfg_req_t            pci_req;
  cfg_req_t            loc_req;
  cfg_rsp_t            pci_rsp;
  cfg_rsp_t            loc_rsp;
  logic                claim;
  logic                expired;
  logic [`LAT_W-1:0]   lat;
  logic                var_o;
  logic [31:0]         rd;
  logic [31:0]         rd2;
  logic                ok;
  logic                ok2;
  int                  fails     = 0;
  int                  num_checks = 0;
  int                  cycles    = 0;
  row_t                rows [14] = '{
    '{1'b0, 1'b0, 1'b0, 2'h0, 4'hf, 32'h0, 32'h0000_0001},
    '{1'b0, 1'b1, 1'b0, 2'h3, 4'hf, 32'h0, 32'h0},
    '{1'b0, 1'b0, 1'b1, 2'h3, 4'hf, 32'hffff_ffff, 32'h0},
    '{1'b0, 1'b1, 1'b0, 2'h3, 4'hf, 32'h0, 32'h0000_ff00},
    '{1'b0, 1'b1, 1'b1, 2'h0, 4'hf, 32'hffff_ffff, 32'h0},
    '{1'b0, 1'b0, 1'b0, 2'h0, 4'hf, 32'h0, 32'h7ff0_0001},
    '{1'b0, 1'b0, 1'b1, 2'h0, 4'h7, 32'h0, 32'h0},
    '{1'b0, 1'b1, 1'b0, 2'h0, 4'hf, 32'h0, 32'h7f00_0001},
    '{1'b0, 1'b0, 1'b1, 2'h2, 4'hf, 32'hffff_ffff, 32'h0},
    '{1'b0, 1'b0, 1'b0, 2'h2, 4'hf, 32'h0, 32'h0},
    '{1'b0, 1'b0, 1'b0, 2'h1, 4'hf, 32'h0, 32'h0},
    '{1'b1, 1'b0, 1'b0, 2'h0, 4'hf, 32'h0, 32'h0000_0001},
    '{1'b1, 1'b1, 1'b1, 2'h0, 4'hf, 32'hffff_ffff, 32'h0},
    '{1'b1, 1'b0, 1'b0, 2'h0, 4'hf, 32'h0, 32'hffff_ff01}};

  pci_config_header_regs i_pci_config_header_regs (
    .core_clk_i(clk), .rst_b_i(rst_b), .soft_rst_i(soft_rst), .enhanced_variant_i(enh),
    .pci_cfg_req_i(pci_req), .pci_cfg_rsp_o(pci_rsp), .local_req_i(loc_req), .local_rsp_o(loc_rsp),
    .io_cmd_valid_i(io_valid), .io_addr_i(io_addr), .io_claim_o(claim), .tenure_start_i(t_start),
    .tenure_active_i(t_active), .tenure_expired_o(expired), .master_latency_timer_o(lat),
    .variant_enhanced_o(var_o));
  cfg_host pci_host (.core_clk_i(clk), .req_o(pci_req), .rsp_i(pci_rsp));
  cfg_host local_host (.core_clk_i(clk), .req_o(loc_req), .rsp_i(loc_rsp));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic do_reset(input logic v);
    rst_b <= 1'b0;
    enh <= v;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    // strap is caught at the first edge and its copy shows after the second
    repeat (3) @(posedge clk);
  endtask

  // command pulse, then claim sampled one edge after it was taken
  task automatic io_try(input logic [31:0] a, input logic exp);
    @(posedge clk);
    io_valid <= 1'b1;
    io_addr <= a;
    @(posedge clk);
    io_valid <= 1'b0;
    io_addr <= ~a;
    @(posedge clk);
    check({31'h0, claim}, {31'h0, exp});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      fails++;
      report_and_stop();
    end
  end

  initial
  begin
    do_reset(1'b0);
    check({31'h0, var_o}, 32'h0);
    foreach (rows[i])
    begin
      if (rows[i].v !== enh)
      begin
        do_reset(rows[i].v);
        check({31'h0, var_o}, {31'h0, rows[i].v});
      end
      if (rows[i].lp)
        local_host.access(rows[i].w, rows[i].idx, rows[i].be, rows[i].wd, rd, ok);
      else
        pci_host.access(rows[i].w, rows[i].idx, rows[i].be, rows[i].wd, rd, ok);
      check({31'h0, ok}, 32'h1);
      if (!rows[i].w)
        check(rd, rows[i].exp);
    end
    // enhanced window of 256 bytes now sits at 0xffffff00
    io_try(32'hffff_ff40, 1'b1);
    io_try(32'hffff_fe40, 1'b0);
    pci_host.access(1'b1, `IDX_HDR_MISC, 4'h2, 32'h0000_0200, rd, ok);
    @(posedge clk);
    check({24'h0, lat}, 32'h2);
    t_start <= 1'b1;
    t_active <= 1'b1;
    @(posedge clk);
    t_start <= 1'b0;
    @(posedge clk);
    check({31'h0, expired}, 32'h0);
    @(posedge clk);
    check({31'h0, expired}, 32'h0);
    // expiry is registered at the edge where the count hits zero
    @(posedge clk);
    check({31'h0, expired}, 32'h1);
    t_active <= 1'b0;
    // both ports write the latency byte together; pci side takes it
    fork
      pci_host.access(1'b1, `IDX_HDR_MISC, 4'hf, 32'h0000_1200, rd, ok);
      local_host.access(1'b1, `IDX_HDR_MISC, 4'hf, 32'h0000_3400, rd2, ok2);
    join
    pci_host.access(1'b0, `IDX_HDR_MISC, 4'hf, 32'h0, rd, ok);
    check(rd, 32'h0000_1200);
    @(posedge clk);
    soft_rst <= 1'b1;
    @(posedge clk);
    soft_rst <= 1'b0;
    pci_host.access(1'b0, `IDX_HDR_MISC, 4'hf, 32'h0, rd, ok);
    check(rd, `HDR_MISC_RST);
    local_host.access(1'b0, `IDX_IO_BASE, 4'hf, 32'h0, rd, ok);
    check(rd, `IO_BASE_RST);
    report_and_stop();
  end
endmodule
